// ### link_gpio_cfg.svh
// offsets, field positions, reset values and timing counts of the pin bridge
`ifndef LINK_GPIO_CFG_SVH
`define LINK_GPIO_CFG_SVH
// device registers, reached by back-channel commands
`define REG_LOCAL_PIN_DATA 8'h0d
`define REG_PIN_DIRECTION 8'h0e
`define REG_FWD_PIN_CFG 8'h0f
`define REG_PIN_LEVEL_STATUS 8'h53
`define DIR_RESET 8'h0f
`define DATA_RESET 8'h00
`define FWD_CFG_RESET 8'h00
// back frame: [29:28] command, [27:20] address, [19:12] data, [11:8] pins
`define BF_CMD 29:28
`define BF_ADDR 27:20
`define BF_DATA 19:12
`define BF_PINS 11:8
// forward frame: [39] inversion flag, [38] reply, [37:30] read data,
// [29:26] pin samples, [25] sample valid, [24:22] mode
`define FF_INV 39
`define FF_REPLY 38
`define FF_RDATA 37:30
`define FF_PINS 29:26
`define FF_SVALID 25
`define FF_MODE 24:22
// link timing: back-channel rates in kbit/s at a 40 ns clock
`define CLK_PERIOD_NS 40
`define BC_FRAME_BITS 30
`define BC_RATE_SYNC_KBPS 50000
`define BC_RATE_NONSYNC_KBPS 10000
`define BC_RATE_DVP_KBPS 2500
`define BC_CYCLES(k) ((`BC_FRAME_BITS * 1000000) / ((k) * `CLK_PERIOD_NS))
// controller registers on the AXI4-Lite side
`define AXI_WRITE_CMD 8'h00
`define AXI_READ_CMD 8'h04
`define AXI_STATUS 8'h08
`define AXI_BC_PINS 8'h0c
`define AXI_FSYNC 8'h10
`endif

// ### link_gpio_pkg.sv
// types shared by both ends of the pin bridge link
package link_gpio_pkg;
   typedef enum logic [1:0] {CMD_NOP, CMD_WRITE, CMD_READ} bc_cmd_e;
   typedef enum logic [1:0] {REF_BACK_CHANNEL, REF_EXTERNAL, REF_INTERNAL} ref_src_e;
   typedef enum logic [1:0] {CLS_SYNC, CLS_NONSYNC, CLS_DVP} mode_class_e;

   // strap code to clocking class: 0 sync, 5 parallel legacy, others non-sync
   function automatic mode_class_e mode_class(input logic [2:0] m);
      if (m == 3'h0)
         return CLS_SYNC;
      else if (m == 3'h5)
         return CLS_DVP;
      else
         return CLS_NONSYNC;
   endfunction
endpackage

// ### link_if.sv
// frame-level serial link between the camera-side device and the far end
`timescale 1ns/1ps
interface link_if;
   logic [39:0] fwd_frame;
   logic fwd_valid;
   logic [29:0] bck_frame;
   logic bck_valid;
   modport dev (output fwd_frame, output fwd_valid, input bck_frame, input bck_valid);
   modport far (input fwd_frame, input fwd_valid, output bck_frame, output bck_valid);
endinterface // link_if

// ### link_gpio_bridge.sv
// camera-side pin bridge: four pins, local registers, forward sampling, back-channel outputs
`timescale 1ns/1ps
`include "link_gpio_cfg.svh"
module link_gpio_bridge (
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // strap and sensing
   input wire logic [2:0] mode_strap,
   input wire logic [1:0] vsense_high,
   // pins
   input wire logic [3:0] gpio_in,
   output logic [3:0] gpio_out,
   output logic [3:0] gpio_oe,
   // reference clock selection
   output link_gpio_pkg::ref_src_e ref_src,
   output logic [2:0] mode,
   // link
   link_if.dev lnk
);
   import link_gpio_pkg::*;

   logic [7:0] data_r;
   logic [7:0] dir_r;
   logic [7:0] fwd_cfg_r;
   logic [2:0] mode_r;
   logic strap_taken_r;
   logic reply_pend_r;
   logic [7:0] reply_data_r;
   logic [3:0] bc_pins_r;
   logic [2:0] frame_cnt_r;
   logic [3:0] sample_r;
   logic sample_new_r;
   logic inv_r;
   logic [38:0] body;
   bc_cmd_e cmd;
   logic [7:0] addr;
   logic [7:0] wdata;

   // frames the sample period spans for a forwarded pin count
   function automatic logic [2:0] sample_period(input logic [2:0] n);
      if (n <= 3'h1)
         return 3'h1;
      else if (n == 3'h2)
         return 3'h2;
      else
         return 3'h5;
   endfunction

   // which pins take part in forwarding, lowest pins first
   function automatic logic [3:0] fwd_mask(input logic [2:0] n);
      logic [3:0] m;
      m = 4'h0;
      for (int i = 0; i < 4; i++)
         if (3'(i) < n)
            m[i] = 1'b1;
      return m;
   endfunction

   // register read decode; status shows pad levels whatever the direction
   function automatic logic [7:0] reg_read(input logic [7:0] a);
      unique case (a)
         `REG_LOCAL_PIN_DATA: return data_r;
         `REG_PIN_DIRECTION: return dir_r;
         `REG_FWD_PIN_CFG: return fwd_cfg_r;
         `REG_PIN_LEVEL_STATUS: return {2'h0, vsense_high, gpio_in};
         default: return 8'h00;
      endcase
   endfunction

   assign cmd = bc_cmd_e'(lnk.bck_frame[`BF_CMD]);
   assign addr = lnk.bck_frame[`BF_ADDR];
   assign wdata = lnk.bck_frame[`BF_DATA];

   // strap is caught in the first enabled cycle after reset release
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         mode_r <= 3'h0;
         strap_taken_r <= 1'b0;
      end
      else if (ce && !strap_taken_r)
      begin
         mode_r <= mode_strap;
         strap_taken_r <= 1'b1;
      end

   // reference source follows the strapped clocking class; strap 3 picks the internal source
   always_ff @(posedge aclk)
      if (!aresetn)
         ref_src <= REF_BACK_CHANNEL;
      else if (ce)
         unique case (mode_class(mode_r))
            CLS_SYNC: ref_src <= REF_BACK_CHANNEL;
            CLS_DVP: ref_src <= REF_EXTERNAL;
            default: ref_src <= (mode_r == 3'h3) ? REF_INTERNAL : REF_EXTERNAL;
         endcase

   always_ff @(posedge aclk)
      if (!aresetn)
         mode <= 3'h0;
      else if (ce)
         mode <= mode_r;

   // register writes arrive as back-channel commands
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         data_r <= `DATA_RESET;
         dir_r <= `DIR_RESET;
         fwd_cfg_r <= `FWD_CFG_RESET;
      end
      else if (ce && lnk.bck_valid && cmd == CMD_WRITE)
      begin
         if (addr == `REG_LOCAL_PIN_DATA)
            data_r <= wdata;
         if (addr == `REG_PIN_DIRECTION)
            dir_r <= wdata;
         if (addr == `REG_FWD_PIN_CFG)
            fwd_cfg_r <= {5'h0, (wdata[2:0] > 3'h4) ? 3'h4 : wdata[2:0]};
      end

   // read replies ride the next forward frame
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         reply_pend_r <= 1'b0;
         reply_data_r <= 8'h00;
      end
      else if (ce)
      begin
         if (lnk.bck_valid && cmd == CMD_READ)
         begin
            reply_pend_r <= 1'b1;
            reply_data_r <= reg_read(addr);
         end
         else
            reply_pend_r <= 1'b0;
      end

   // remote pin values, frame sync among them, held between back frames
   always_ff @(posedge aclk)
      if (!aresetn)
         bc_pins_r <= 4'h0;
      else if (ce && lnk.bck_valid)
         bc_pins_r <= lnk.bck_frame[`BF_PINS];

   // pin drivers: each pin drives only when its output enable is set
   generate
      for (genvar p = 0; p < 4; p++)
      begin : g_pin
         always_ff @(posedge aclk)
            if (!aresetn)
            begin
               gpio_out[p] <= 1'b0;
               gpio_oe[p] <= 1'b0;
            end
            else if (ce)
            begin
               gpio_out[p] <= data_r[4 + p] ? bc_pins_r[p] : data_r[p];
               gpio_oe[p] <= dir_r[4 + p];
            end
      end
   endgenerate

   // one forward frame per clock; sampling spread over 1, 2 or 5 frames
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         frame_cnt_r <= 3'h0;
         sample_r <= 4'h0;
         sample_new_r <= 1'b0;
      end
      else if (ce)
      begin
         if (frame_cnt_r + 3'h1 >= sample_period(fwd_cfg_r[2:0]))
         begin
            frame_cnt_r <= 3'h0;
            sample_r <= gpio_in & fwd_mask(fwd_cfg_r[2:0]) & dir_r[3:0];
            sample_new_r <= (fwd_cfg_r[2:0] != 3'h0);
         end
         else
         begin
            frame_cnt_r <= frame_cnt_r + 3'h1;
            sample_new_r <= 1'b0;
         end
      end

   // frame body; payload bits below the mode field are idle zeros
   always_comb
   begin
      body = 39'h0;
      body[`FF_REPLY] = reply_pend_r;
      body[`FF_RDATA] = reply_data_r;
      body[`FF_PINS] = sample_r;
      body[`FF_SVALID] = sample_new_r;
      body[`FF_MODE] = mode_r;
   end

   // alternate frames are sent inverted to keep the line balanced
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         inv_r <= 1'b0;
         lnk.fwd_frame <= 40'h0;
         lnk.fwd_valid <= 1'b0;
      end
      else if (ce)
      begin
         inv_r <= ~inv_r;
         lnk.fwd_frame <= {inv_r, inv_r ? ~body : body};
         lnk.fwd_valid <= strap_taken_r;
      end
endmodule // link_gpio_bridge

// ### link_gpio_far.sv
// far-end controller: AXI4-Lite registers, back-channel commands, frame sync generator
`timescale 1ns/1ps
`include "link_gpio_cfg.svh"
module link_gpio_far (
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // link
   link_if.far lnk
);
   import link_gpio_pkg::*;

   logic [7:0] awaddr_r;
   logic aw_have_r;
   logic [31:0] wdata_r;
   logic w_have_r;
   logic [17:0] cmd_r;
   logic cmd_pend_r;
   logic busy_r;
   logic rd_done_r;
   logic [7:0] rd_data_r;
   logic [3:0] fwd_pins_r;
   logic [2:0] dev_mode_r;
   logic [3:0] bc_pins_r;
   logic [31:0] fsync_r;
   logic [15:0] fs_cnt_r;
   logic fs_level_r;
   logic [8:0] bc_cnt_r;
   logic [38:0] fbody;
   logic [8:0] bc_period;
   logic [3:0] pins_out;
   logic do_write;

   assign fbody = lnk.fwd_frame[`FF_INV] ? ~lnk.fwd_frame[38:0] : lnk.fwd_frame[38:0];
   assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;

   // back frame spacing per clocking class of the device
   always_comb
      unique case (mode_class(dev_mode_r))
         CLS_SYNC: bc_period = 9'(`BC_CYCLES(`BC_RATE_SYNC_KBPS));
         CLS_DVP: bc_period = 9'(`BC_CYCLES(`BC_RATE_DVP_KBPS));
         default: bc_period = 9'(`BC_CYCLES(`BC_RATE_NONSYNC_KBPS));
      endcase

   // write address and data are caught separately, in either order
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else if (ce)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
         end
         if (do_write)
         begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_r > `AXI_FSYNC || awaddr_r[1:0] != 2'h0) ? 2'h2 : 2'h0;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end

   always_comb
   begin
      s_axi_awready = !aw_have_r && !s_axi_bvalid;
      s_axi_wready = !w_have_r && !s_axi_bvalid;
   end

   // software-owned pin values and frame sync setup
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         bc_pins_r <= 4'h0;
         fsync_r <= 32'h0;
      end
      else if (ce && do_write && s_axi_wstrb[0])
      begin
         if (awaddr_r == `AXI_BC_PINS)
            bc_pins_r <= wdata_r[3:0];
         if (awaddr_r == `AXI_FSYNC)
            fsync_r <= wdata_r;
      end

   // one device command in flight; launched by a write, retired by frame or reply
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         cmd_r <= 18'h0;
         cmd_pend_r <= 1'b0;
         busy_r <= 1'b0;
         rd_done_r <= 1'b0;
         rd_data_r <= 8'h00;
      end
      else if (ce)
      begin
         if (do_write && !busy_r && (awaddr_r == `AXI_WRITE_CMD || awaddr_r == `AXI_READ_CMD))
         begin
            cmd_r <= {(awaddr_r == `AXI_READ_CMD) ? CMD_READ : CMD_WRITE, wdata_r[15:0]};
            cmd_pend_r <= 1'b1;
            busy_r <= 1'b1;
            rd_done_r <= 1'b0;
         end
         else
         begin
            if (cmd_pend_r && bc_cnt_r == 9'h0)
            begin
               cmd_pend_r <= 1'b0;
               if (bc_cmd_e'(cmd_r[17:16]) == CMD_WRITE)
                  busy_r <= 1'b0;
            end
            if (lnk.fwd_valid && fbody[`FF_REPLY])
            begin
               rd_data_r <= fbody[`FF_RDATA];
               rd_done_r <= 1'b1;
               busy_r <= 1'b0;
            end
         end
      end

   // forwarded samples and the device mode seen in forward frames
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         fwd_pins_r <= 4'h0;
         dev_mode_r <= 3'h0;
      end
      else if (ce && lnk.fwd_valid)
      begin
         dev_mode_r <= fbody[`FF_MODE];
         if (fbody[`FF_SVALID])
            fwd_pins_r <= fbody[`FF_PINS];
      end

   // frame sync: one back frame high in every period of the programmed number plus one back frames
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         fs_cnt_r <= 16'h0;
         fs_level_r <= 1'b0;
      end
      else if (ce && bc_cnt_r == 9'h0)
      begin
         if (!fsync_r[0] || fs_cnt_r >= fsync_r[31:16])
            fs_cnt_r <= 16'h0;
         else
            fs_cnt_r <= fs_cnt_r + 16'h1;
         fs_level_r <= fsync_r[0] && fs_cnt_r == 16'h0;
      end

   always_comb
   begin
      pins_out = bc_pins_r;
      if (fsync_r[0])
         pins_out[fsync_r[2:1]] = fs_level_r;
   end

   // back frames at the rate of the clocking class
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         bc_cnt_r <= 9'h0;
         lnk.bck_valid <= 1'b0;
         lnk.bck_frame <= 30'h0;
      end
      else if (ce)
      begin
         bc_cnt_r <= (bc_cnt_r + 9'h1 >= bc_period) ? 9'h0 : bc_cnt_r + 9'h1;
         lnk.bck_valid <= (bc_cnt_r == 9'h0);
         if (bc_cnt_r == 9'h0)
            lnk.bck_frame <= {cmd_pend_r ? cmd_r : 18'h0, pins_out, 8'h00};
      end

   // read channel: answer one cycle after the address is taken
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end
      else if (ce)
      begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            unique case (s_axi_araddr)
               `AXI_STATUS: s_axi_rdata <= {9'h0, dev_mode_r, fwd_pins_r, rd_data_r, 6'h0, rd_done_r, busy_r};
               `AXI_BC_PINS: s_axi_rdata <= {28'h0, bc_pins_r};
               `AXI_FSYNC: s_axi_rdata <= fsync_r;
               `AXI_WRITE_CMD, `AXI_READ_CMD: s_axi_rdata <= 32'h0;
               default:
               begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
endmodule // link_gpio_far

// ### link_gpio_properties.sv
// concurrent checks on the frame link between the device end and the far end
`timescale 1ns/1ps
module link_gpio_properties (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // link
   input wire logic [39:0] fwd_frame,
   input wire logic fwd_valid,
   input wire logic [29:0] bck_frame,
   input wire logic bck_valid
);
   logic [38:0] body;
   logic [8:0] gap_exp;
   logic rd_cmd;
   logic [8:0] gap_r;
   logic [1:0] seen_r;

   // undo the balancing inversion so that the fields can be read
   assign body = fwd_frame[39] ? ~fwd_frame[38:0] : fwd_frame[38:0];
   assign rd_cmd = bck_valid && (bck_frame[29:28] == 2'h2);
   assign gap_exp = (body[24:22] == 3'h0) ? 9'h00f : ((body[24:22] == 3'h5) ? 9'h12c : 9'h04b);

   // cycles since the last back frame; the first gaps are skipped while the far end learns the mode
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         gap_r <= 9'h000;
         seen_r <= 2'h0;
      end
      else
      begin
         gap_r <= bck_valid ? 9'h001 : ((gap_r == 9'h1ff) ? gap_r : gap_r + 9'h001);
         seen_r <= (bck_valid && seen_r != 2'h3) ? seen_r + 2'h1 : seen_r;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_inv_toggle;
      fwd_valid ##1 fwd_valid |-> fwd_frame[39] != $past(fwd_frame[39]);
   endproperty
   a_inv_toggle: assert property (p_inv_toggle) else $error("inversion flag did not alternate");
   property p_fwd_steady;
      $rose(fwd_valid) |=> fwd_valid [*8];
   endproperty
   a_fwd_steady: assert property (p_fwd_steady) else $error("forward frames stopped");
   property p_bck_pulse;
      bck_valid |=> !bck_valid;
   endproperty
   a_bck_pulse: assert property (p_bck_pulse) else $error("back frame strobe too long");
   property p_bck_pad;
      bck_valid |-> bck_frame[7:0] == 8'h00;
   endproperty
   a_bck_pad: assert property (p_bck_pad) else $error("back frame padding not zero");
   property p_bck_cmd;
      bck_valid |-> bck_frame[29:28] != 2'h3;
   endproperty
   a_bck_cmd: assert property (p_bck_cmd) else $error("illegal back frame command");
   property p_bck_gap;
      bck_valid && seen_r == 2'h3 |-> gap_r == gap_exp;
   endproperty
   a_bck_gap: assert property (p_bck_gap) else $error("back frame spacing wrong for mode");
   property p_mode_stable;
      fwd_valid ##1 fwd_valid |-> $stable(body[24:22]);
   endproperty
   a_mode_stable: assert property (p_mode_stable) else $error("captured mode changed");
   property p_reply;
      fwd_valid |-> body[38] == $past(rd_cmd, 2);
   endproperty
   a_reply: assert property (p_reply) else $error("read reply at wrong frame");

   // main scenarios
   c_sample: cover property (fwd_valid && body[25]);
   c_read: cover property (rd_cmd);
   c_write: cover property (bck_valid && bck_frame[29:28] == 2'h1);
endmodule // link_gpio_properties

// ### link_gpio_bridge_tb.sv
// self-checking bench: both link ends joined, driven from the AXI4-Lite side and the pins
`timescale 1ns/1ps
`include "link_gpio_cfg.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t ns: got %h expected %h", $time, a, e); end end
module link_gpio_bridge_tb;
   import link_gpio_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [2:0] mode_strap = 3'h0;
   logic [1:0] vsense_high = 2'h0;
   logic [3:0] gpio_in = 4'h0;
   logic [3:0] gpio_out;
   logic [3:0] gpio_oe;
   ref_src_e ref_src;
   logic [2:0] mode;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   int error_cnt = 0;
   int checks_done = 0;

   link_if lnk ();
   link_gpio_bridge link_gpio_bridge_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .mode_strap(mode_strap),
      .vsense_high(vsense_high), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .ref_src(ref_src),
      .mode(mode), .lnk(lnk));
   link_gpio_far link_gpio_far_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .lnk(lnk));
   link_gpio_properties link_gpio_properties_inst (.aclk(aclk), .aresetn(aresetn), .fwd_frame(lnk.fwd_frame),
      .fwd_valid(lnk.fwd_valid), .bck_frame(lnk.bck_frame), .bck_valid(lnk.bck_valid));

   always #20 aclk = ~aclk;

   task end_of_test;
      $display("mismatches %0d, comparisons %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // each bus and reset task starts one edge later, so no signal is assigned twice in a time step
   // waits as long as the slave needs; only the watchdog ends a hung transfer
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      r = 2'h3;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready)
         begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      r = 2'h3;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready)
         begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   // poll controller status until the command left, and for reads until the reply came
   task automatic dev_cmd(input logic [7:0] c, input logic [15:0] v, output logic [7:0] d);
      logic [31:0] st;
      logic [1:0] r;
      int n;
      n = 0;
      axi_wr(c, {16'h0, v}, r);
      do
      begin
         axi_rd(`AXI_STATUS, st, r);
         n++;
      end
      while ((st[0] || (c == `AXI_READ_CMD && !st[1])) && n < 100);
      if (st[0] !== 1'b0)
         error_cnt++;
      d = st[15:8];
   endtask

   task automatic do_reset;
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
   endtask

   task automatic t_modes;
      logic [2:0] s [4] = '{3'h3, 3'h5, 3'h2, 3'h0};
      ref_src_e e;
      for (int i = 0; i < 4; i++)
      begin
         mode_strap <= s[i];
         do_reset;
         e = (s[i] == 3'h0) ? REF_BACK_CHANNEL : ((s[i] == 3'h3) ? REF_INTERNAL : REF_EXTERNAL);
         `CHK(mode, s[i])
         `CHK(ref_src, e)
      end
      // a strap moved after power-up must not change the mode
      mode_strap <= 3'h5;
      repeat (5) @(posedge aclk);
      `CHK(mode, 3'h0)
      mode_strap <= 3'h0;
   endtask

   task automatic t_regs;
      logic [7:0] d;
      logic [31:0] w;
      logic [1:0] r;
      gpio_in <= 4'ha;
      vsense_high <= 2'h2;
      dev_cmd(`AXI_READ_CMD, {`REG_PIN_DIRECTION, 8'h00}, d);
      `CHK(d, 8'h0f)
      `CHK(gpio_oe, 4'h0)
      dev_cmd(`AXI_READ_CMD, {`REG_PIN_LEVEL_STATUS, 8'h00}, d);
      `CHK(d, 8'h2a)
      dev_cmd(`AXI_READ_CMD, {8'h20, 8'h00}, d);
      `CHK(d, 8'h00)
      axi_rd(8'h40, w, r);
      `CHK(r, 2'h2)
      axi_wr(8'h02, 32'h0, r);
      `CHK(r, 2'h2)
   endtask

   task automatic t_dir;
      logic [7:0] dirs [3] = '{8'hf0, 8'h3c, 8'h00};
      logic [3:0] oes [3] = '{4'hf, 4'h3, 4'h0};
      logic [7:0] d;
      logic [1:0] r;
      dev_cmd(`AXI_WRITE_CMD, {`REG_LOCAL_PIN_DATA, 8'h05}, d);
      // enables are never set for both directions of one pin
      for (int i = 0; i < 3; i++)
      begin
         dev_cmd(`AXI_WRITE_CMD, {`REG_PIN_DIRECTION, dirs[i]}, d);
         repeat (2) @(posedge aclk);
         `CHK(gpio_oe, oes[i])
         `CHK(gpio_out & gpio_oe, 4'h5 & oes[i])
         dev_cmd(`AXI_READ_CMD, {`REG_PIN_LEVEL_STATUS, 8'h00}, d);
         `CHK(d[3:0], 4'ha)
      end
      // pins 3 and 2 follow the back channel, pins 1 and 0 keep local data
      dev_cmd(`AXI_WRITE_CMD, {`REG_PIN_DIRECTION, 8'hf0}, d);
      dev_cmd(`AXI_WRITE_CMD, {`REG_LOCAL_PIN_DATA, 8'hc5}, d);
      axi_wr(`AXI_BC_PINS, 32'h8, r);
      repeat (60) @(posedge aclk);
      `CHK(gpio_out, 4'h9)
   endtask

   task automatic t_fwd;
      logic [7:0] d;
      logic [38:0] b;
      int cnt;
      logic [3:0] mask;
      logic [31:0] w;
      logic [1:0] r;
      dev_cmd(`AXI_WRITE_CMD, {`REG_PIN_DIRECTION, 8'h0f}, d);
      gpio_in <= 4'hb;
      for (int n = 0; n < 5; n++)
      begin
         dev_cmd(`AXI_WRITE_CMD, {`REG_FWD_PIN_CFG, 8'(n)}, d);
         repeat (10) @(posedge aclk);
         mask = 4'hb & ((4'h1 << n) - 4'h1);
         cnt = 0;
         repeat (40)
         begin
            @(posedge aclk);
            b = lnk.fwd_frame[39] ? ~lnk.fwd_frame[38:0] : lnk.fwd_frame[38:0];
            if (lnk.fwd_valid === 1'b1 && b[25] === 1'b1)
            begin
               cnt++;
               `CHK(b[29:26], mask)
            end
         end
         `CHK(cnt, (n == 0) ? 0 : 40 / ((n < 3) ? n : 5))
      end
      // the far end reports the last forwarded samples and the device mode
      axi_rd(`AXI_STATUS, w, r);
      `CHK(w[19:16], 4'hb)
      `CHK(w[22:20], 3'h0)
   endtask

   task automatic wait_lvl(input logic v, output int c);
      c = 0;
      while (gpio_out[2] !== v && c < 400)
      begin
         @(posedge aclk);
         c++;
      end
   endtask

   task automatic t_fsync;
      logic [7:0] d;
      logic [1:0] r;
      int c;
      int hi;
      int lo;
      dev_cmd(`AXI_WRITE_CMD, {`REG_PIN_DIRECTION, 8'h40}, d);
      dev_cmd(`AXI_WRITE_CMD, {`REG_LOCAL_PIN_DATA, 8'h40}, d);
      axi_wr(`AXI_BC_PINS, 32'h0, r);
      axi_wr(`AXI_FSYNC, {16'h0004, 13'h0000, 2'h2, 1'h1}, r);
      // skip a possibly partial pulse, then time a whole one
      wait_lvl(1'b1, c);
      wait_lvl(1'b0, c);
      wait_lvl(1'b1, c);
      wait_lvl(1'b0, hi);
      wait_lvl(1'b1, lo);
      `CHK(hi, 15)
      // the generator counts 0 up to the programmed value, so 4 gives five back frames per pulse
      `CHK(hi + lo, 75)
      axi_wr(`AXI_FSYNC, 32'h0, r);
   endtask

   initial
   begin
      do_reset;
      t_modes;
      t_regs;
      t_dir;
      t_fwd;
      t_fsync;
      end_of_test;
   end

   // cut a hang short well beyond the expected run length
   initial
   begin
      repeat (60000) @(posedge aclk);
      error_cnt++;
      end_of_test;
   end
endmodule // link_gpio_bridge_tb
